// ===== design/vml_mode_ctrl.sv
// mode control (idle, active, sleep) and channel register file with link resolution
// assumes a serial front end delivers one-cycle byte read/write strobes on mclk_i
`timescale 1ns/1ps
`include "vml_defines.svh"
// What this block does
// - after reset the device sits in idle mode, not active
// - idle keeps clock output toggling but no frame sent or received
// - idle holds bus transmit output released, external pull-up keeps level
// - activate, idle, sleep bits live in command register at 0x03
// - line status at 0x04 shows idle state on entry and exit
// - sleep bit enters sleep whatever activate and idle hold
// - entering sleep clears internal state and stops the oscillator at once
// - asleep: all register accesses refused, clock output not driven
// - only hardware reset or software reset leaves sleep
// - channel with zero 5-bit length is linked to another channel
// - linked channel's 7-bit pointer names the shared channel
// - linked area pointer and length come from referenced channel only
// - all other channel fields stay independent, tag included
// - shared areas lie within the common 128-byte message area
// - idle request waits until pending transmit attempts finish
module vml_mode_ctrl (
    // clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 srst_i,
    // asynchronous software reset request from serial front end
    input  wire logic                 swrst_i,
    // register access
    input  wire vml_pkg::vml_req_type req_i,
    output logic [7:0]                rdata_o,
    output logic                      rvalid_o,
    output logic                      refused_o,
    // transmit engine status
    input  wire logic                 tx_busy_i,
    // bus transmit pin
    input  wire logic                 txd_i,
    output logic                      txd_o,
    output logic                      txd_oe_o,
    // clock output and oscillator
    output logic                      buffered_clock_output_o,
    output logic                      buffered_clock_output_oe_o,
    output logic                      osc_run_o,
    // mode
    output logic                      active_o,
    // link query
    input  wire logic [3:0]           chan_sel_i,
    output vml_pkg::vml_area_type     area_o
);
    typedef struct packed {
        vml_pkg::vml_mode_type mode;
        logic [7:0]            cmd;
        logic [13:0][7:0]      ptr;
        logic [13:0][7:0]      len;
        logic [13:0][7:0]      tag;
        logic [7:0]            rdata;
        logic                  rvalid;
        logic                  refused;
        logic                  txd;
        logic                  txd_oe;
        logic                  buffered_clock_output;
        logic                  buffered_clock_output_oe;
        logic                  osc_run;
        logic                  active;
        logic                  sw1;
        logic                  sw2;
        vml_pkg::vml_area_type area;
    } vml_state_type;

    vml_state_type         s_q;
    vml_state_type         s_d;
    vml_pkg::vml_area_type area_w;
    logic                  chan_hit;
    logic [3:0]            chan_idx;
    logic [2:0]            chan_reg;
    logic [7:0]            chan_off;
    logic                  wr_ok;
    wire logic [13:0][7:0] ptr_nx;
    wire logic [13:0][7:0] len_nx;
    wire logic [13:0][7:0] tag_nx;

    vml_link_resolve u_resolve (
        .ptr_i  (s_q.ptr),
        .len_i  (s_q.len),
        .chan_i (chan_sel_i),
        .area_o (area_w)
    );

    always_comb begin
        chan_off = req_i.addr - `VML_CHAN_BASE;
        chan_idx = chan_off[6:3];
        chan_reg = chan_off[2:0];
        // top offset bit checked so high addresses never alias onto channel 0
        chan_hit = (req_i.addr >= `VML_CHAN_BASE) && !chan_off[7]
                   && (chan_idx < 4'(`VML_NUM_CHAN));
        // nothing is stored while asleep
        wr_ok    = (s_q.mode != vml_pkg::MODE_SLEEP) && req_i.we;
    end

    // one write tap per register set; a store to one field leaves the others alone
    for (genvar g = 0; g < `VML_NUM_CHAN; g++) begin : g_chan
        wire logic hit;
        assign hit       = wr_ok && chan_hit && (chan_idx == 4'(g));
        assign ptr_nx[g] = (hit && chan_reg == `VML_CHAN_PTR_OFS) ? req_i.wdata : s_q.ptr[g];
        assign len_nx[g] = (hit && chan_reg == `VML_CHAN_LEN_OFS) ? req_i.wdata : s_q.len[g];
        assign tag_nx[g] = (hit && chan_reg == `VML_CHAN_TAG_OFS) ? req_i.wdata : s_q.tag[g];
    end

    always_comb begin
        s_d          = s_q;
        s_d.rvalid   = 1'b0;
        s_d.refused  = 1'b0;
        s_d.sw1      = swrst_i;
        s_d.sw2      = s_q.sw1;
        s_d.area     = area_w;
        s_d.txd      = 1'b1;
        // register writes; each field stored per channel, tag never shared
        if (wr_ok && req_i.addr == `VML_CMD_OFS) begin
            s_d.cmd = req_i.wdata;
        end
        s_d.ptr = ptr_nx;
        s_d.len = len_nx;
        s_d.tag = tag_nx;
        // register reads
        if (s_q.mode != vml_pkg::MODE_SLEEP && req_i.re) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = 8'h0_0;
            if (req_i.addr == `VML_CMD_OFS) begin
                s_d.rdata = s_q.cmd;
            end else if (req_i.addr == `VML_LINE_OFS) begin
                s_d.rdata[`VML_LINE_IDLE_BIT] = (s_q.mode == vml_pkg::MODE_IDLE);
            end else if (chan_hit) begin
                if (chan_reg == `VML_CHAN_PTR_OFS) begin
                    s_d.rdata = s_q.ptr[chan_idx];
                end else if (chan_reg == `VML_CHAN_LEN_OFS) begin
                    s_d.rdata = s_q.len[chan_idx];
                end else if (chan_reg == `VML_CHAN_TAG_OFS) begin
                    s_d.rdata = s_q.tag[chan_idx];
                end
            end
        end
        if (s_q.mode == vml_pkg::MODE_SLEEP && (req_i.we || req_i.re)) begin
            s_d.refused = 1'b1;
        end
        // mode sequencing
        unique case (s_q.mode)
            vml_pkg::MODE_IDLE: begin
                if (s_d.cmd[`VML_CMD_SLEEP_BIT]) begin
                    s_d.mode = vml_pkg::MODE_SLEEP;
                end else if (s_d.cmd[`VML_CMD_ACTIVATE_COMMAND_BIT_BIT] && !s_d.cmd[`VML_CMD_IDLE_BIT]) begin
                    s_d.mode = vml_pkg::MODE_ACTIVE;
                end
            end
            vml_pkg::MODE_ACTIVE: begin
                if (s_d.cmd[`VML_CMD_SLEEP_BIT]) begin
                    s_d.mode = vml_pkg::MODE_SLEEP;
                end else if (s_d.cmd[`VML_CMD_IDLE_BIT] && !tx_busy_i) begin
                    // pending attempts drain before the bus is released
                    s_d.mode = vml_pkg::MODE_IDLE;
                end
            end
            vml_pkg::MODE_SLEEP: begin
                s_d.mode = vml_pkg::MODE_SLEEP;
            end
            default: begin
                // unused code falls back to idle
                s_d.mode = vml_pkg::MODE_IDLE;
            end
        endcase
        // pin and clock outputs follow the next mode
        s_d.active   = (s_d.mode == vml_pkg::MODE_ACTIVE);
        s_d.txd_oe   = s_d.active && !txd_i;
        s_d.txd      = 1'b0;
        s_d.osc_run  = (s_d.mode != vml_pkg::MODE_SLEEP);
        s_d.buffered_clock_output_oe = s_d.osc_run;
        s_d.buffered_clock_output    = s_d.osc_run ? !s_q.buffered_clock_output : 1'b0;
        if (s_d.mode == vml_pkg::MODE_SLEEP) begin
            // non-user state parked low to save power
            s_d.rdata = 8'h0_0;
            s_d.area  = '0;
        end
        // software reset: synchronised, acts like hardware reset
        if (s_q.sw2) begin
            s_d      = '0;
            s_d.cmd  = `VML_CMD_RESET;
            s_d.mode = vml_pkg::MODE_IDLE;
            // idle keeps the oscillator running, so it restarts at once
            s_d.osc_run  = 1'b1;
            s_d.buffered_clock_output_oe = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s_q      <= '0;
            s_q.cmd  <= `VML_CMD_RESET;
            s_q.mode <= vml_pkg::MODE_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o    = s_q.rdata;
    assign rvalid_o   = s_q.rvalid;
    assign refused_o  = s_q.refused;
    assign txd_o      = s_q.txd;
    assign txd_oe_o   = s_q.txd_oe;
    assign buffered_clock_output_o    = s_q.buffered_clock_output;
    assign buffered_clock_output_oe_o = s_q.buffered_clock_output_oe;
    assign osc_run_o  = s_q.osc_run;
    assign active_o   = s_q.active;
    assign area_o     = s_q.area;
endmodule : vml_mode_ctrl

// ===== design/vml_defines.svh
// register offsets, field positions, reset values for the mode and channel link block
// assumes byte-wide register access from the serial slave front end
`ifndef VML_DEFINES_SVH
`define VML_DEFINES_SVH
`define VML_CMD_OFS        8'h03
`define VML_LINE_OFS       8'h04
`define VML_CHAN_BASE      8'h10
`define VML_CHAN_STRIDE    8'h08
`define VML_CHAN_PTR_OFS   3'h2
`define VML_CHAN_LEN_OFS   3'h3
`define VML_CHAN_TAG_OFS   3'h0
`define VML_CMD_ACTIVATE_COMMAND_BIT_BIT   0
`define VML_CMD_IDLE_BIT   1
`define VML_CMD_SLEEP_BIT  2
`define VML_LINE_IDLE_BIT  0
`define VML_LINE_SLEEP_BIT 1
`define VML_CMD_RESET      8'h02
`define VML_LEN_MSB        4
`define VML_PTR_MSB        6
`define VML_MSG_BYTES      128
`define VML_NUM_CHAN       14
`endif

// ===== design/vml_pkg.sv
// types for the mode and channel link block
// assumes vml_defines.svh is included by users of the numbers
package vml_pkg;
    typedef enum logic [1:0] {MODE_IDLE, MODE_ACTIVE, MODE_SLEEP} vml_mode_type;
    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vml_req_type;
    typedef struct packed {
        logic [6:0] ptr;
        logic [4:0] len;
        logic       linked;
        logic       bad;
    } vml_area_type;
endpackage : vml_pkg

// ===== design/vml_link_resolve.sv
// resolves one channel's message area through at most one link
// assumes pointer and length tables are stable flops of the caller
`timescale 1ns/1ps
module vml_link_resolve (
    // tables
    input  wire logic [13:0][7:0] ptr_i,
    input  wire logic [13:0][7:0] len_i,
    // query
    input  wire logic [3:0]       chan_i,
    output vml_pkg::vml_area_type area_o
);
    logic [3:0] ref_idx;
    always_comb begin
        area_o  = '0;
        ref_idx = 4'h0;
        if (chan_i < 4'(14)) begin
            if (len_i[chan_i][4:0] != 5'h0_0) begin
                area_o.ptr = ptr_i[chan_i][6:0];
                area_o.len = len_i[chan_i][4:0];
            end else begin
                area_o.linked = 1'b1;
                ref_idx = ptr_i[chan_i][3:0];
                // only one hop: a linked target is flagged, never followed
                if (ptr_i[chan_i][6:0] >= 7'(14) || len_i[ref_idx][4:0] == 5'h0_0) begin
                    area_o.bad = 1'b1;
                end else begin
                    area_o.ptr = ptr_i[ref_idx][6:0];
                    area_o.len = len_i[ref_idx][4:0];
                end
            end
        end
    end
endmodule : vml_link_resolve

// ===== tb/vml_mode_checker.sv
// port assertions for the mode controller
// assumes bind onto vml_mode_ctrl, single mclk_i domain
`timescale 1ns/1ps
module vml_mode_checker (
    // clock, reset, requests
    input wire logic                 mclk_i,
    input wire logic                 srst_i,
    input wire logic                 swrst_i,
    input wire logic                 tx_busy_i,
    input wire vml_pkg::vml_req_type req_i,
    // outputs watched
    input wire logic                 rvalid_o,
    input wire logic                 refused_o,
    input wire logic                 txd_oe_o,
    input wire logic                 buffered_clock_output_o,
    input wire logic                 buffered_clock_output_oe_o,
    input wire logic                 osc_run_o,
    input wire logic                 active_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);
    wire logic cmd_wr;
    assign cmd_wr = req_i.we && req_i.addr == 8'h03;
    // three quiet cycles cover the two-flop wake synchroniser
    sequence s_quiet;
        (!osc_run_o && !swrst_i) [*3];
    endsequence
    sequence s_awake;
        osc_run_o && buffered_clock_output_oe_o && !active_o;
    endsequence
    AST_RST_IDLE: assert property (disable iff (1'b0) srst_i |=> !active_o)
        else $error("active after reset");
    AST_TXD_IDLE: assert property (!active_o && !$past(active_o) |-> !txd_oe_o)
        else $error("transmit driven while idle");
    AST_CK_TOGGLE: assert property (buffered_clock_output_oe_o && $past(buffered_clock_output_oe_o) && !$past(srst_i, 2)
        |-> buffered_clock_output_o != $past(buffered_clock_output_o))
        else $error("clock output stalled");
    AST_ACT_CMD: assert property (cmd_wr && req_i.wdata[2:0] == 3'b001 && osc_run_o
        |=> active_o)
        else $error("activate ignored");
    AST_SLEEP_ENTER: assert property (cmd_wr && req_i.wdata[2] && osc_run_o
        |=> !osc_run_o && !buffered_clock_output_oe_o && !active_o)
        else $error("sleep not entered");
    AST_SLEEP_REFUSE: assert property (!osc_run_o && !swrst_i && !$past(srst_i)
        && (req_i.we || req_i.re)
        |=> refused_o && !rvalid_o)
        else $error("access taken asleep");
    AST_SLEEP_STAY: assert property (s_quiet |=> !osc_run_o && !buffered_clock_output_oe_o)
        else $error("left sleep unasked");
    AST_WAKE: assert property ($rose(swrst_i) && !osc_run_o |-> ##[1:6] s_awake)
        else $error("no wake on soft reset");
    AST_IDLE_WAIT: assert property (active_o && tx_busy_i && !req_i.we |=> active_o)
        else $error("idle while transmit busy");
endmodule : vml_mode_checker

bind vml_mode_ctrl vml_mode_checker i_vml_mode_checker (
    .mclk_i(mclk_i), .srst_i(srst_i), .swrst_i(swrst_i), .tx_busy_i(tx_busy_i),
    .req_i(req_i), .rvalid_o(rvalid_o), .refused_o(refused_o), .txd_oe_o(txd_oe_o),
    .buffered_clock_output_o(buffered_clock_output_o), .buffered_clock_output_oe_o(buffered_clock_output_oe_o), .osc_run_o(osc_run_o), .active_o(active_o));

// ===== tb/vml_host_model.sv
// host model: byte accesses and software reset
// assumes req_i taken on rising mclk_i
`timescale 1ns/1ps
module vml_host_model (
    // clock and answers
    input  wire logic            mclk_i,
    input  wire logic [7:0]      rdata_i,
    input  wire logic            rvalid_i,
    input  wire logic            refused_i,
    // requests
    output vml_pkg::vml_req_type req_o,
    output logic                 swrst_o
);
    initial begin
        req_o = '0;
        swrst_o = 1'b0;
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        req_o = {1'b1, 1'b0, a, d};
        @(negedge mclk_i);
        req_o = '0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d, output logic refd);
        d = 8'hxx;
        refd = 1'b0;
        @(negedge mclk_i);
        req_o = {1'b0, 1'b1, a, 8'h00};
        for (int n = 0; n < 4; n++) begin
            @(negedge mclk_i);
            req_o = '0;
            if (rvalid_i || refused_i) begin
                d = rdata_i;
                refd = refused_i;
                break;
            end
        end
    endtask : rd
    // wake only through the software reset line
    task wake;
        @(negedge mclk_i);
        swrst_o = 1'b1;
        repeat (3) @(negedge mclk_i);
        swrst_o = 1'b0;
    endtask : wake
endmodule : vml_host_model

// ===== tb/test_van_mode_and_channel_link.sv
// bench for the mode controller and channel links
// assumes host model issues accesses, bench drives the rest on falling edges
`timescale 1ns/1ps
module test_van_mode_and_channel_link;
    logic                  mclk_i, srst_i, swrst_i, tx_busy_i, txd_i, rf;
    logic                  rvalid_o, refused_o, txd_o, txd_oe_o, buffered_clock_output_o, buffered_clock_output_oe_o;
    logic                  osc_run_o, active_o;
    logic [3:0]            chan_sel_i;
    logic [7:0]            rdata_o, rv;
    vml_pkg::vml_req_type  req_i;
    vml_pkg::vml_area_type area_o;
    int                    failures, checks_done;
    wire logic [15:0]      flg = {11'h000, txd_o, osc_run_o, buffered_clock_output_oe_o, active_o, txd_oe_o};
    vml_mode_ctrl i_vml_mode_ctrl (.mclk_i(mclk_i), .srst_i(srst_i), .swrst_i(swrst_i),
        .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .refused_o(refused_o),
        .tx_busy_i(tx_busy_i), .txd_i(txd_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o),
        .buffered_clock_output_o(buffered_clock_output_o), .buffered_clock_output_oe_o(buffered_clock_output_oe_o), .osc_run_o(osc_run_o),
        .active_o(active_o), .chan_sel_i(chan_sel_i), .area_o(area_o));
    vml_host_model u_host (.mclk_i(mclk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
        .refused_i(refused_o), .req_o(req_i), .swrst_o(swrst_i));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rs(input logic [3:0] c);
        @(negedge mclk_i);
        chan_sel_i = c;
        repeat (2) @(negedge mclk_i);
    endtask : rs
    task t_active;
        u_host.wr(8'h03, 8'h01);
        @(negedge mclk_i);
        chk(flg, 16'h000f);
        txd_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        chk(flg, 16'h000e);
        rv[0] = buffered_clock_output_o;
        @(negedge mclk_i);
        chk({15'h0000, buffered_clock_output_o ^ rv[0]}, 16'h0001);
        u_host.rd(8'h04, rv, rf);
        chk({15'h0000, rv[0]}, 16'h0000);
        tx_busy_i = 1'b1;
        u_host.wr(8'h03, 8'h02);
        repeat (5) @(negedge mclk_i);
        chk({15'h0000, active_o}, 16'h0001);
        tx_busy_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        u_host.rd(8'h04, rv, rf);
        chk({14'h0000, active_o, rv[0]}, 16'h0001);
    endtask : t_active
    task t_link;
        // ch2 links to unlinked ch1; ch3 chains onto ch2, ch4 points past the last channel
        logic [15:0] tbl [10] = '{16'h18aa, 16'h1a20, 16'h1b08, 16'h2055, 16'h2201,
                                 16'h2300, 16'h2a02, 16'h2b00, 16'h320e, 16'h3300};
        foreach (tbl[i]) u_host.wr(tbl[i][15:8], tbl[i][7:0]);
        rs(4'h1);
        chk({2'b00, area_o}, {2'b00, 7'h20, 5'h08, 2'b00});
        rs(4'h2);
        chk({2'b00, area_o}, {2'b00, 7'h20, 5'h08, 2'b10});
        rs(4'h3);
        chk({15'h0000, area_o.bad}, 16'h0001);
        rs(4'h4);
        chk({15'h0000, area_o.bad}, 16'h0001);
        u_host.rd(8'h18, rv, rf);
        chk({8'h00, rv}, 16'h00aa);
        u_host.rd(8'h20, rv, rf);
        chk({8'h00, rv}, 16'h0055);
        u_host.rd(8'h1a, rv, rf);
        chk({8'h00, rv}, 16'h0020);
    endtask : t_link
    task t_sleep;
        u_host.wr(8'h03, 8'h07);
        chk(flg, 16'h0000);
        u_host.rd(8'h04, rv, rf);
        chk({15'h0000, rf}, 16'h0001);
        repeat (10) @(negedge mclk_i);
        chk(flg, 16'h0000);
        chk({15'h0000, buffered_clock_output_o}, 16'h0000);
        u_host.wake;
        repeat (6) @(negedge mclk_i);
        u_host.rd(8'h03, rv, rf);
        chk({flg[7:0], rv}, 16'h0c02);
        u_host.wr(8'h03, 8'h01);
        u_host.wr(8'h03, 8'h04);
        chk(flg, 16'h0000);
        srst_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        srst_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        chk(flg, 16'h000c);
    endtask : t_sleep
    task summarize;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    initial begin
        {failures, checks_done} = '0;
        {srst_i, tx_busy_i, txd_i, chan_sel_i} = 7'h40;
        repeat (12) @(negedge mclk_i);
        srst_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        chk(flg, 16'h000c);
        u_host.rd(8'h03, rv, rf);
        chk({8'h00, rv}, 16'h0002);
        t_active;
        t_link;
        t_sleep;
        summarize;
    end
    initial begin
        #300000;
        failures++;
        summarize;
    end
endmodule : test_van_mode_and_channel_link
